// ---- hdl/rate_policy.sv ----
`timescale 1ns/100ps
// Carrier speed and re-negotiation policy with its settings registers.
module rate_policy
  import rate_policy_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Settings command port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_num,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Other command settings
  input  wire logic [2:0] highest_speed_setting,
  input  wire logic       fixed_speed_mode,
  input  wire logic       auto_retrain_option,
  input  wire logic       trellis_control_command,
  input  wire logic [1:0] sync_clock_option,
  input  wire logic [2:0] dte_mode,
  input  wire logic       bsc_in_use,
  input  wire logic       sync_bridge_mode,
  input  wire logic [1:0] dte_speed_code,
  input  wire logic       clamp_option,
  // Events from the line side
  input  wire logic       connect_start,
  input  wire logic       handshake_done,
  input  wire logic       retrain_done,
  input  wire logic       reneg_done,
  input  wire logic       hangup,
  input  wire logic       manual_renegotiate_command,
  input  wire logic       remote_reneg_request,
  input  wire logic [1:0] measured_quality,
  input  wire logic       error_correction_active,
  input  wire logic       frame_errors_high,
  input  wire logic       frame_errors_low,
  // Decisions
  output logic [9:0]      max_frame_bytes,
  output logic            use_v32bis,
  output logic            trellis_enable,
  output logic [2:0]      line_speed,
  output logic [4:0]      offered_speeds,
  output logic            no_v32bis_speed,
  output logic            connect_refused,
  output logic            retrain_req,
  output logic            reneg_req,
  output logic            reneg_answer,
  output logic            clamp_cts_rd,
  output logic            speed_change_allowed
);
  // Call progress: idle, carrier handshake, data, retrain and rate exchange.
  typedef enum logic [2:0] {ST_IDLE, ST_HANDSHAKE, ST_ONLINE, ST_RETRAIN, ST_RENEG} state_t;

  // All state lives in one record: settings, call progress and request pulses.
  typedef struct packed {
    state_t     st;
    logic [7:0] frame_sel;
    logic [7:0] quality_thr;
    logic [7:0] speed_mask;
    logic [7:0] hs_sel;
    logic [2:0] speed;
    logic [2:0] init_speed;
    logic [2:0] cap_speed;
    logic [2:0] target;
    logic       refused;
    logic       retrain_p;
    logic       reneg_p;
    logic       answer_p;
    logic       answering;
    logic [7:0] rdata;
    logic [9:0] frame_bytes;
    logic [4:0] offer;
  } regs_t;

  regs_t q, d;

  // Speed index that a terminal speed supports in sync bridge mode.
  function automatic logic [2:0] bridge_cap(input logic [1:0] code);
    unique case (code)
      DTE_9600:  bridge_cap = SPD_4800;
      DTE_19200: bridge_cap = SPD_12000;
      default:   bridge_cap = SPD_14400;
    endcase
  endfunction

  function automatic logic is_sync(input logic [2:0] m);
    is_sync = (m == DTE_SYNC_ONE) || (m == DTE_SYNC_TWO) || (m == DTE_SYNC_THREE);
  endfunction

  // A synchronous mode clocked from the terminal side ties the line rate to that clock.
  function automatic logic sync_on_alt(input logic [2:0] m, input logic [1:0] c);
    sync_on_alt = is_sync(m) && (c == CLK_ALTERNATE);
  endfunction

  // Constant terminal speed modes buffer the data, so the line rate is free to move.
  function automatic logic is_const(input logic [2:0] m);
    is_const = (m == DTE_CONST_BRIDGE) || (m == DTE_CONST_EC) || (m == DTE_CONST_PLAIN);
  endfunction

  // Modes in which, without error correction, signal quality is the only measure.
  function automatic logic quality_judged(input logic [2:0] m, input logic bsc, input logic [1:0] c);
    quality_judged = (m == DTE_CONST_PLAIN) || ((m == DTE_CONST_BRIDGE) && bsc) ||
                     (is_sync(m) && (c == CLK_PRIMARY));
  endfunction

  // Decisions shared by the state machine and the outputs.
  logic [4:0] enabled;
  logic       bis;
  logic       q_low;
  logic       change_ok;
  logic       auto_ok;
  logic       basis_bad;
  logic       raise_ok;
  logic [2:0] pick_limit;
  logic       pick_found;
  logic [2:0] pick_speed;
  logic [2:0] raise_limit;
  logic [2:0] step_limit;

  // Reserved mask bits are dropped here, so they can never reach a decision.
  assign enabled    = q.speed_mask[MASK_LSB +: NUM_SPEEDS];
  assign bis        = (q.hs_sel != 8'(HS_V32));
  // Threshold 0 means no limit, so quality can never fall below it.
  assign q_low      = bis && (q.quality_thr != 8'h00) &&
                      ({6'h00, measured_quality} < q.quality_thr);
  assign change_ok  = is_const(dte_mode) ||
                      (is_sync(dte_mode) && !sync_on_alt(dte_mode, sync_clock_option));
  // Automatic re-negotiation needs select 2 and a mode whose line rate may move.
  assign auto_ok    = (q.hs_sel == 8'(HS_V32BIS_AUTO)) && (dte_mode != DTE_ASYNC) &&
                      !sync_on_alt(dte_mode, sync_clock_option) &&
                      change_ok;
  // Error correction judges by frame errors, otherwise by quality in the listed modes.
  always_comb begin
    if (error_correction_active) begin
      basis_bad = frame_errors_high;
    end else if (quality_judged(dte_mode, bsc_in_use, sync_clock_option)) begin
      basis_bad = q_low;
    end else begin
      basis_bad = 1'b0;
    end
  end
  // Raising only with error control; never when judged by quality alone.
  assign raise_ok   = error_correction_active && frame_errors_low &&
                      (q.speed < raise_limit);
  assign raise_limit = sync_bridge_mode ?
                       ((q.cap_speed > q.init_speed) ? q.cap_speed : q.init_speed) :
                       SPD_14400;
  // The slowest speed has nothing below it; callers guard against stepping from it.
  assign step_limit = (q.speed == SPD_4800) ? SPD_4800 : 3'(q.speed - 3'h1);

  // The single picker serves the handshake start, step-down and raise.
  // Raising is only looked for online, so a handshake fallback can never climb.
  always_comb begin
    if (q.st == ST_IDLE) begin
      pick_limit = highest_speed_setting;
    end else if ((q.st == ST_ONLINE) && raise_ok && !basis_bad) begin
      pick_limit = raise_limit;
    end else begin
      pick_limit = step_limit;
    end
  end

  // Highest enabled speed at or below the chosen limit.
  speed_pick u_pick (
    .enabled (enabled),
    .limit   (pick_limit),
    .found   (pick_found),
    .speed   (pick_speed)
  );

  always_comb begin
    d = q;
    d.retrain_p = 1'b0;
    d.reneg_p   = 1'b0;
    d.answer_p  = 1'b0;
    // Out-of-range writes are dropped and leave the setting as it was.
    if (reg_wr) begin
      unique case (reg_num)
        REG_FRAME_SIZE: begin
          if ((reg_wdata >= FRAME_CODE_MIN) && (reg_wdata <= FRAME_CODE_MAX)) begin
            d.frame_sel = reg_wdata;
          end
        end
        REG_QUALITY_THR: begin
          if (reg_wdata <= QUALITY_MAX) begin
            d.quality_thr = reg_wdata;
          end
        end
        REG_SPEED_MASK: d.speed_mask = reg_wdata;
        REG_HANDSHAKE: begin
          if (reg_wdata <= HANDSHAKE_MAX) begin
            d.hs_sel = reg_wdata;
          end
        end
        default: ;
      endcase
    end
    // Read data is registered, so it follows the register number by one clock.
    unique case (reg_num)
      REG_FRAME_SIZE:  d.rdata = q.frame_sel;
      REG_QUALITY_THR: d.rdata = q.quality_thr;
      REG_SPEED_MASK:  d.rdata = q.speed_mask;
      REG_HANDSHAKE:   d.rdata = q.hs_sel;
      default:         d.rdata = 8'h00;
    endcase
    // Derived settings are registered with the settings, so they never lag them.
    d.frame_bytes = 10'(10'h001 << d.frame_sel[3:0]);
    d.offer       = d.speed_mask[MASK_LSB +: NUM_SPEEDS];

    // Online events are taken in a fixed order: a hangup first, then a remote request is answered,
    // since ignoring it would leave the far modem waiting; then the manual command;
    // then an automatic retrain on a bad measure; and last an automatic raise.
    // A retrain always comes before any step down, so a passing disturbance does not
    // cost line speed.
    unique case (q.st)
      ST_IDLE: begin
        if (connect_start) begin
          d.refused    = 1'b0;
          d.cap_speed  = bridge_cap(dte_speed_code);
          if (!bis) begin
            // Plain V.32 tops out at 9600.
            d.speed = (highest_speed_setting > SPD_9600) ? SPD_9600 : highest_speed_setting;
            d.st    = ST_HANDSHAKE;
          end else if (fixed_speed_mode) begin
            if ((highest_speed_setting <= SPD_14400) && enabled[highest_speed_setting]) begin
              d.speed = highest_speed_setting;
              d.st    = ST_HANDSHAKE;
            end else begin
              d.refused = 1'b1;
            end
          end else if (pick_found) begin
            d.speed = pick_speed;
            d.st    = ST_HANDSHAKE;
          end else begin
            // No enabled speed at or below the highest setting: report and stay idle.
            d.refused = 1'b1;
          end
        end
      end
      // Each cycle of poor quality steps one enabled speed lower, down to the floor.
      ST_HANDSHAKE: begin
        if (hangup) begin
          d.st = ST_IDLE;
        end else if (q_low && !fixed_speed_mode && pick_found && (q.speed != SPD_4800)) begin
          d.speed = pick_speed;
        end else if (handshake_done) begin
          d.init_speed = q.speed;
          d.st         = ST_ONLINE;
        end
      end
      ST_ONLINE: begin
        if (hangup) begin
          d.st = ST_IDLE;
        end else if (remote_reneg_request && bis) begin
          // The far modem picks from our offer; the target is the current speed, so it stands after the exchange too.
          d.answer_p  = 1'b1;
          d.answering = 1'b1;
          d.target    = q.speed;
          d.st        = ST_RENEG;
        end else if (manual_renegotiate_command && bis) begin
          d.reneg_p   = 1'b1;
          d.answering = 1'b0;
          d.target    = q.speed;
          d.st        = ST_RENEG;
        end else if (basis_bad && bis && (auto_retrain_option || auto_ok)) begin
          d.retrain_p = 1'b1;
          d.st        = ST_RETRAIN;
        end else if (raise_ok && auto_ok && pick_found && (pick_speed > q.speed)) begin
          // Only a strictly faster enabled speed is worth an exchange.
          d.reneg_p   = 1'b1;
          d.answering = 1'b0;
          d.target    = pick_speed;
          d.st        = ST_RENEG;
        end
      end
      ST_RETRAIN: begin
        if (hangup) begin
          d.st = ST_IDLE;
        end else if (retrain_done) begin
          // Still bad after the retrain: re-negotiate one enabled speed lower.
          if (basis_bad && auto_ok && pick_found && (q.speed != SPD_4800)) begin
            d.reneg_p   = 1'b1;
            d.answering = 1'b0;
            d.target    = pick_speed;
            d.st        = ST_RENEG;
          end else begin
            d.st = ST_ONLINE;
          end
        end
      end
      ST_RENEG: begin
        if (hangup) begin
          d.st = ST_IDLE;
        end else if (reneg_done) begin
          d.speed = q.target;
          d.st    = ST_ONLINE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Where the terminal clock fixes the line rate, a finished exchange keeps the old speed.
    if (!speed_change_allowed && (q.st != ST_IDLE) && (q.st != ST_HANDSHAKE)) begin
      d.speed = q.speed;
    end
  end

  always_ff @(posedge core_clk) begin
    // Settings return to their defaults and the call state is cleared.
    if (!resetn) begin
      q             <= '0;
      q.st          <= ST_IDLE;
      q.frame_sel   <= RST_FRAME_SIZE;
      q.quality_thr <= RST_QUALITY_THR;
      q.speed_mask  <= RST_SPEED_MASK;
      q.hs_sel      <= RST_HANDSHAKE;
      q.frame_bytes <= 10'(10'h001 << RST_FRAME_SIZE[3:0]);
      q.offer       <= RST_SPEED_MASK[MASK_LSB +: NUM_SPEEDS];
    end else begin
      q <= d;
    end
  end

  // Settings seen from outside.
  assign max_frame_bytes      = q.frame_bytes;
  assign use_v32bis           = bis;
  assign trellis_enable       = bis | trellis_control_command;
  assign reg_rdata            = q.rdata;

  // Speed in use and the offer made to the far modem.
  assign line_speed           = q.speed;
  assign offered_speeds       = q.offer;
  assign no_v32bis_speed      = (enabled == 5'h00);
  assign connect_refused      = q.refused;

  // Request pulses toward the line side.
  assign retrain_req          = q.retrain_p;
  assign reneg_req            = q.reneg_p;
  assign reneg_answer         = q.answer_p;

  // Terminal-side effects.
  assign clamp_cts_rd         = clamp_option && ((q.st == ST_RETRAIN) || (q.st == ST_RENEG));
  assign speed_change_allowed = change_ok;
endmodule

// ---- hdl/rate_policy_pkg.sv ----
package rate_policy_pkg;
  // Register numbers used by the settings command port.
  localparam logic [7:0] REG_FRAME_SIZE   = 8'h69;
  localparam logic [7:0] REG_QUALITY_THR  = 8'h6C;
  localparam logic [7:0] REG_SPEED_MASK   = 8'h6D;
  localparam logic [7:0] REG_HANDSHAKE    = 8'h6E;
  // Values after reset.
  localparam logic [7:0] RST_FRAME_SIZE   = 8'h07;
  localparam logic [7:0] RST_QUALITY_THR  = 8'h00;
  localparam logic [7:0] RST_SPEED_MASK   = 8'h3E;
  localparam logic [7:0] RST_HANDSHAKE    = 8'h02;
  // Field layout and limits.
  localparam int         MASK_LSB         = 1;
  localparam int         NUM_SPEEDS       = 5;
  localparam logic [7:0] FRAME_CODE_MIN   = 8'h04;
  localparam logic [7:0] FRAME_CODE_MAX   = 8'h09;
  localparam logic [7:0] QUALITY_MAX      = 8'h03;
  localparam logic [7:0] HANDSHAKE_MAX    = 8'h02;
  // Speed indices: 0=4800 1=7200 2=9600 3=12000 4=14400.
  localparam logic [2:0] SPD_4800         = 3'h0;
  localparam logic [2:0] SPD_9600         = 3'h2;
  localparam logic [2:0] SPD_12000        = 3'h3;
  localparam logic [2:0] SPD_14400        = 3'h4;
  // Terminal speed codes fixed at connection in sync bridge mode.
  localparam logic [1:0] DTE_9600         = 2'h0;
  localparam logic [1:0] DTE_19200        = 2'h1;
  localparam logic [1:0] DTE_34400        = 2'h2;

  typedef enum logic [1:0] {HS_V32, HS_V32BIS, HS_V32BIS_AUTO} hs_sel_t;
  typedef enum logic [2:0] {
    DTE_ASYNC, DTE_SYNC_ONE, DTE_SYNC_TWO, DTE_SYNC_THREE,
    DTE_CONST_BRIDGE, DTE_CONST_EC, DTE_CONST_PLAIN
  } dte_mode_t;
  typedef enum logic [1:0] {CLK_PRIMARY, CLK_ALTERNATE, CLK_SECONDARY} sync_clk_t;
endpackage

// ---- hdl/speed_pick.sv ----
`timescale 1ns/100ps
// Picks the highest enabled speed at or below a limit.
module speed_pick
  import rate_policy_pkg::*;
(
  // Query
  input  wire logic [4:0] enabled,
  input  wire logic [2:0] limit,
  // Result
  output logic            found,
  output logic [2:0]      speed
);
  always_comb begin
    found = 1'b0;
    speed = SPD_4800;
    for (int i = 0; i < NUM_SPEEDS; i++) begin
      if (enabled[i] && (3'(i) <= limit)) begin
        found = 1'b1;
        speed = 3'(i);
      end
    end
  end
endmodule

// ---- testbench/rate_policy_bench.sv ----
`timescale 1ns/100ps
module rate_policy_bench
  import rate_policy_pkg::*;
;
  logic       core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, fixed_speed_mode = 1'b0, hangup = 1'b0;
  logic       auto_retrain_option = 1'b0, trellis_control_command = 1'b0, bsc_in_use = 1'b0;
  logic       clamp_option = 1'b0, connect_start = 1'b0, ask_reneg = 1'b0, manual_renegotiate_command = 1'b0;
  logic       error_correction_active = 1'b0, frame_errors_high = 1'b0, frame_errors_low = 1'b0;
  logic       sync_bridge_mode = 1'b0;
  logic [7:0] reg_num = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic [2:0] highest_speed_setting = 3'h4, dte_mode = 3'h6, line_speed;
  logic [1:0] sync_clock_option = 2'h0, measured_quality = 2'h3, dte_speed_code = 2'h0;
  logic       handshake_done, retrain_done, reneg_done, remote_reneg_request, use_v32bis, trellis_enable;
  logic       no_v32bis_speed, connect_refused, retrain_req, reneg_req, reneg_answer, clamp_cts_rd;
  logic       speed_change_allowed;
  logic [9:0] max_frame_bytes;
  logic [4:0] offered_speeds;
  int         num_errors = 0, comparisons = 0, i, j;

  rate_policy DUT (.core_clk, .resetn, .reg_wr, .reg_num, .reg_wdata, .reg_rdata, .highest_speed_setting,
    .fixed_speed_mode, .auto_retrain_option, .trellis_control_command, .sync_clock_option, .dte_mode,
    .bsc_in_use, .sync_bridge_mode, .dte_speed_code, .clamp_option, .connect_start,
    .handshake_done, .retrain_done, .reneg_done, .hangup, .manual_renegotiate_command, .remote_reneg_request,
    .measured_quality, .error_correction_active, .frame_errors_high, .frame_errors_low,
    .max_frame_bytes, .use_v32bis, .trellis_enable, .line_speed, .offered_speeds, .no_v32bis_speed,
    .connect_refused, .retrain_req, .reneg_req, .reneg_answer, .clamp_cts_rd, .speed_change_allowed);
  remote_modem #(.DELAY(10)) far_end (.core_clk, .connect_start, .retrain_req, .reneg_req, .reneg_answer,
    .ask_reneg, .handshake_done, .retrain_done, .reneg_done, .remote_reneg_request);

  always #20 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] n, input logic [7:0] d);
    tick(1);
    reg_wr = 1'b1;
    reg_num = n;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] n);
    tick(1);
    reg_num = n;
    tick(1);
    rv = reg_rdata;
  endtask
  task automatic call();
    tick(1);
    connect_start = 1'b1;
    tick(1);
    connect_start = 1'b0;
  endtask
  task automatic hang();
    tick(1);
    hangup = 1'b1;
    tick(1);
    hangup = 1'b0;
  endtask

  task automatic t_regs();
    logic [7:0] num [4] = '{REG_FRAME_SIZE, REG_QUALITY_THR, REG_SPEED_MASK, REG_HANDSHAKE};
    logic [7:0] exp [4] = '{8'h07, 8'h00, 8'h3E, 8'h02};
    logic [7:0] bad [4] = '{8'h0A, 8'h04, 8'h3E, 8'h03};
    for (j = 0; j < 2; j++)
      for (i = 0; i < 4; i++) begin
        if (j == 1) wr(num[i], bad[i]);
        rd(num[i]);
        chk("register", 10'(exp[i]), 10'(rv));
      end
    rd(8'h6B);
    chk("unmapped", 10'h000, 10'(rv));
    $display("t_regs done");
  endtask

  task automatic t_frame();
    for (i = 4; i < 10; i++) begin
      wr(REG_FRAME_SIZE, 8'(i));
      chk("frame bytes", 10'(16 << (i - 4)), max_frame_bytes);
    end
    for (i = 0; i < 4; i++) begin
      wr(REG_QUALITY_THR, 8'(i));
      rd(REG_QUALITY_THR);
      chk("threshold", 10'(i), 10'(rv));
    end
    wr(REG_FRAME_SIZE, 8'h07);
    wr(REG_SPEED_MASK, 8'hC1);
    chk("offer empty", 10'h001, 10'(no_v32bis_speed));
    chk("offer", 10'h000, 10'(offered_speeds));
    wr(REG_SPEED_MASK, 8'h3E);
    chk("offer", 10'h01F, 10'(offered_speeds));
    $display("t_frame done");
  endtask

  task automatic t_fall();
    logic [7:0] hs  [3] = '{8'h02, 8'h02, 8'h00};
    logic [2:0] exp [3] = '{3'h0, 3'h4, 3'h2};
    measured_quality = 2'h1;
    for (i = 0; i < 3; i++) begin
      wr(REG_HANDSHAKE, hs[i]);
      fixed_speed_mode = (i == 1);
      call();
      tick(8);
      chk("fallback speed", 10'(exp[i]), 10'(line_speed));
      tick(6);
      hang();
    end
    wr(REG_HANDSHAKE, 8'h02);
    fixed_speed_mode = 1'b1;
    wr(REG_SPEED_MASK, 8'h0C);
    call();
    chk("refused", 10'h001, 10'(connect_refused));
    fixed_speed_mode = 1'b0;
    wr(REG_SPEED_MASK, 8'h3E);
    call();
    chk("accepted", 10'h000, 10'(connect_refused));
    hang();
    $display("t_fall done");
  endtask

  task automatic t_online();
    measured_quality = 2'h3;
    clamp_option = 1'b1;
    call();
    tick(12);
    ask_reneg = 1'b1;
    tick(1);
    ask_reneg = 1'b0;
    tick(1);
    chk("answer", 10'h001, 10'(reneg_answer));
    chk("clamp", 10'h001, 10'(clamp_cts_rd));
    chk("speed kept", 10'h004, 10'(line_speed));
    tick(14);
    chk("clamp off", 10'h000, 10'(clamp_cts_rd));
    manual_renegotiate_command = 1'b1;
    tick(1);
    manual_renegotiate_command = 1'b0;
    chk("manual", 10'h001, 10'(reneg_req));
    tick(14);
    auto_retrain_option = 1'b1;
    measured_quality = 2'h0;
    for (i = 0; i < 6 && retrain_req !== 1'b1; i++) tick(1);
    chk("retrain", 10'h001, 10'(retrain_req));
    hang();
    $display("t_online done");
  endtask

  task automatic t_raise();
    auto_retrain_option = 1'b0;
    measured_quality = 2'h3;
    highest_speed_setting = 3'h1;
    sync_bridge_mode = 1'b1;
    dte_speed_code = DTE_19200;
    error_correction_active = 1'b1;
    frame_errors_low = 1'b1;
    call();
    tick(30);
    chk("raise cap", 10'(SPD_12000), 10'(line_speed));
    frame_errors_low = 1'b0;
    frame_errors_high = 1'b1;
    for (i = 0; i < 6 && retrain_req !== 1'b1; i++) tick(1);
    chk("frame retrain", 10'h001, 10'(retrain_req));
    hang();
    error_correction_active = 1'b0;
    frame_errors_high = 1'b0;
    frame_errors_low = 1'b1;
    call();
    tick(30);
    chk("no raise", 10'h001, 10'(line_speed));
    hang();
    highest_speed_setting = SPD_14400;
    sync_bridge_mode = 1'b0;
    $display("t_raise done");
  endtask

  task automatic t_modes();
    for (i = 0; i < 7; i++)
      for (j = 0; j < 3; j++) begin
        dte_mode = 3'(i);
        sync_clock_option = 2'(j);
        bsc_in_use = i[0];
        tick(1);
        chk("speed change", 10'(i > 3 || (i > 0 && j != 1)), 10'(speed_change_allowed));
      end
    wr(REG_HANDSHAKE, 8'h00);
    for (i = 0; i < 2; i++) begin
      trellis_control_command = i[0];
      tick(1);
      chk("trellis", 10'(i), 10'(trellis_enable));
    end
    chk("v32bis", 10'h000, 10'(use_v32bis));
    wr(REG_HANDSHAKE, 8'h01);
    chk("v32bis", 10'h001, 10'(use_v32bis));
    $display("t_modes done");
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    tick(10);
    resetn = 1'b1;
    t_regs();
    t_frame();
    t_fall();
    t_online();
    t_raise();
    t_modes();
    close_out();
  end
  // The tests take well under 1000 cycles; 5000 cycles means a hang.
  initial begin
    #200_000;
    num_errors++;
    close_out();
  end
endmodule

// ---- testbench/rate_policy_sva.sv ----
`timescale 1ns/100ps
// Watches the policy ports for decisions that contradict the settings.
module rate_policy_sva
  import rate_policy_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Watched inputs
  input wire logic       remote_reneg_request,
  input wire logic       manual_renegotiate_command,
  input wire logic       trellis_control_command,
  input wire logic       clamp_option,
  input wire logic       connect_start,
  input wire logic [1:0] sync_clock_option,
  input wire logic [2:0] dte_mode,
  // Watched decisions
  input wire logic [9:0] max_frame_bytes,
  input wire logic       use_v32bis,
  input wire logic       trellis_enable,
  input wire logic [4:0] offered_speeds,
  input wire logic       no_v32bis_speed,
  input wire logic       connect_refused,
  input wire logic       reneg_req,
  input wire logic       reneg_answer,
  input wire logic       clamp_cts_rd,
  input wire logic       speed_change_allowed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_asked;
    $past(remote_reneg_request) && $past(use_v32bis);
  endsequence
  sequence s_one_pulse;
    reneg_answer ##1 !reneg_answer;
  endsequence

  chk_reset_values: assert property (disable iff (1'b0) !resetn |=> max_frame_bytes == 10'h080 && use_v32bis)
    else $error("frame size or handshake select wrong after reset");
  chk_empty_offer: assert property (no_v32bis_speed == (offered_speeds == 5'h00))
    else $error("empty offer flag disagrees with offered speeds");
  chk_trellis_select: assert property (trellis_enable == (use_v32bis || trellis_control_command))
    else $error("trellis enable does not follow handshake select");
  chk_remote_answer: assert property (reneg_answer |-> s_asked)
    else $error("answer given without a remote request in V.32bis");
  chk_answer_pulse: assert property (reneg_answer |-> s_one_pulse)
    else $error("answer pulse longer than one cycle");
  chk_v32_no_reneg: assert property (reneg_req |-> $past(use_v32bis))
    else $error("re-negotiation started in V.32 mode");
  chk_auto_blocked: assert property (reneg_req && !$past(manual_renegotiate_command) |->
    $past(dte_mode) != DTE_ASYNC && !($past(dte_mode) inside {DTE_SYNC_ONE, DTE_SYNC_TWO, DTE_SYNC_THREE}
    && $past(sync_clock_option) == CLK_ALTERNATE))
    else $error("automatic re-negotiation in a suppressed mode");
  chk_clamp_cause: assert property (clamp_cts_rd |-> clamp_option)
    else $error("lines clamped without the clamp option");
  chk_refused_hold: assert property ($changed(connect_refused) |-> $past(connect_start) || !$past(resetn))
    else $error("refusal changed without a connect attempt");
  chk_speed_modes: assert property (dte_mode == DTE_ASYNC || (dte_mode inside {DTE_SYNC_ONE, DTE_SYNC_TWO,
    DTE_SYNC_THREE} && sync_clock_option == CLK_ALTERNATE) |-> !speed_change_allowed)
    else $error("speed change allowed in a fixed terminal speed mode");
endmodule

bind rate_policy rate_policy_sva u_sva (.core_clk, .resetn, .remote_reneg_request, .manual_renegotiate_command,
  .trellis_control_command, .clamp_option, .connect_start, .sync_clock_option, .dte_mode, .max_frame_bytes,
  .use_v32bis, .trellis_enable, .offered_speeds, .no_v32bis_speed, .connect_refused, .reneg_req,
  .reneg_answer, .clamp_cts_rd, .speed_change_allowed);

// ---- testbench/remote_modem.sv ----
`timescale 1ns/100ps
// Far modem: completes handshakes, retrains and re-negotiations after a delay.
module remote_modem #(
  parameter int DELAY = 10
) (
  // Clock
  input  wire logic core_clk,
  // From the local policy
  input  wire logic connect_start,
  input  wire logic retrain_req,
  input  wire logic reneg_req,
  input  wire logic reneg_answer,
  // Request command from the bench
  input  wire logic ask_reneg,
  // To the local policy
  output logic      handshake_done = 1'b0,
  output logic      retrain_done = 1'b0,
  output logic      reneg_done = 1'b0,
  output logic      remote_reneg_request = 1'b0
);
  int   hs_n  = 0;
  int   tr_n  = 0;
  int   rn_n  = 0;
  logic ask_q = 1'b0;

  // Inputs are read at the rising edge, before the policy's registers update.
  always @(posedge core_clk) begin
    hs_n = connect_start ? DELAY : (hs_n > 0 ? hs_n - 1 : 0);
    tr_n = retrain_req ? DELAY : (tr_n > 0 ? tr_n - 1 : 0);
    rn_n = (reneg_req || reneg_answer) ? DELAY : (rn_n > 0 ? rn_n - 1 : 0);
    ask_q = ask_reneg;
  end
  always @(negedge core_clk) begin
    handshake_done <= (hs_n == 1);
    retrain_done <= (tr_n == 1);
    reneg_done <= (rn_n == 1);
    remote_reneg_request <= ask_q;
  end
endmodule
